// ===== port_e_pkg.sv
// Shared constants for the three-pin port and its slave port link
package port_e_pkg;
  // Register indexes; the byte address on the bus is four times the index
  localparam logic [7:0] SLAVE_DATA_IDX  = 8'h08;
  localparam logic [7:0] PIN_VALUE_IDX   = 8'h09;
  localparam logic [7:0] DIR_CTRL_IDX    = 8'h89;
  localparam logic [7:0] ANALOG_CFG_IDX  = 8'h9f;
  localparam logic [7:0] IRQ_STATUS_IDX  = 8'ha0;
  localparam logic [7:0] IRQ_MASK_IDX    = 8'ha1;
  // Microprocessor-side controller registers
  localparam logic [7:0] HOST_CTRL_IDX   = 8'h00;
  localparam logic [7:0] HOST_WDATA_IDX  = 8'h01;
  localparam logic [7:0] HOST_RDATA_IDX  = 8'h02;
  localparam logic [7:0] HOST_STATUS_IDX = 8'h03;
  // Direction and slave control register fields
  localparam int IN_FULL_BIT   = 7;
  localparam int OUT_FULL_BIT  = 6;
  localparam int IN_OVF_BIT    = 5;
  localparam int SLV_MODE_BIT  = 4;
  localparam logic [7:0] DIR_CTRL_WMASK = 8'h37;
  localparam logic [2:0] DIR_RESET      = 3'h7;
  localparam logic [2:0] ANALOG_RESET   = 3'h0;
  localparam logic [2:0] ALL_DIGITAL    = 3'h7;
  localparam logic [2:0] MOST_DIGITAL   = 3'h6;
  // Control pin positions in slave mode
  localparam int RD_PIN = 0;
  localparam int WR_PIN = 1;
  localparam int CS_PIN = 2;
  // Interrupt status bits
  localparam int EV_IN_BIT   = 0;
  localparam int EV_OUT_BIT  = 1;
  localparam int EV_OVF_BIT  = 2;
  // Host controller fields
  localparam int HC_WRITE_BIT = 0;
  localparam int HC_READ_BIT  = 1;
  localparam int HC_DRIVE_BIT = 2;
  // Strobe timing of the microprocessor end
  localparam int CLK_MHZ       = 50;
  localparam int STROBE_NS     = 200;
  localparam int RECOVER_NS    = 100;
  localparam int STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC   = (RECOVER_NS * CLK_MHZ + 999) / 1000;
endpackage : port_e_pkg

// ===== port_e_if.sv
// Pin-level link between the port device and the external microprocessor
`timescale 1ns/1ps
interface port_e_if;
  logic [2:0] pe_dev_o;
  logic [2:0] pe_dev_oe;
  logic [2:0] pe_ext_o;
  logic [2:0] pe_ext_oe;
  logic [2:0] pe;
  logic [7:0] d_dev_o;
  logic       d_dev_oe;
  logic [7:0] d_ext_o;
  logic       d_ext_oe;
  logic [7:0] d;

  // Wire levels; undriven lines float high through pull-ups
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pe_dev_oe[i]) begin
        pe[i] = pe_dev_o[i];
      end else if (pe_ext_oe[i]) begin
        pe[i] = pe_ext_o[i];
      end else begin
        pe[i] = 1'b1;
      end
    end
    if (d_dev_oe) begin
      d = d_dev_o;
    end else if (d_ext_oe) begin
      d = d_ext_o;
    end else begin
      d = 8'hff;
    end
  end

  modport device (output pe_dev_o, output pe_dev_oe, output d_dev_o,
                  output d_dev_oe, input pe, input d);
  modport host (output pe_ext_o, output pe_ext_oe, output d_ext_o,
                output d_ext_oe, input pe, input d);
endinterface : port_e_if

// ===== upc_end.sv
// External microprocessor end driving the slave port strobes
`timescale 1ns/1ps
module upc_end
  import port_e_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_cyc_i,
  output logic                  wb_ack_o,
  port_e_if.host                link
);
  typedef enum {IDLE, STROBE, RECOVER} host_state_t;
  host_state_t state_q;
  logic [7:0]  cnt_q;
  logic        is_read_q;
  logic        drive_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [7:0]  d_s1_q;
  logic [7:0]  d_s2_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        acc;
  logic        wr_acc;
  logic [7:0]  idx;

  assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_acc = acc & wb_we_i & wb_sel_i[0];
  assign idx    = wb_adr_i[9:2];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Strobes stay high outside a cycle; select and strobe fall together
  assign link.pe_ext_oe = {3{drive_q}};
  assign link.pe_ext_o[CS_PIN] = ~(state_q == STROBE);                 // [RULE13]
  assign link.pe_ext_o[RD_PIN] = ~(state_q == STROBE && is_read_q);    // [RULE11] [RULE15]
  assign link.pe_ext_o[WR_PIN] = ~(state_q == STROBE && !is_read_q);   // [RULE12] [RULE14]
  assign link.d_ext_o  = wdata_q;
  assign link.d_ext_oe = drive_q && state_q == STROBE && !is_read_q;

  // Read data passes two flops before use
  always_ff @(posedge clk_i) begin
    d_s1_q   <= link.d;
    d_s2_q   <= d_s1_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= IDLE;
      cnt_q     <= 8'h00;
      is_read_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      case (state_q)
        IDLE: begin
          if (wr_acc && idx == HOST_CTRL_IDX &&
              (wb_dat_i[HC_WRITE_BIT] || wb_dat_i[HC_READ_BIT])) begin
            is_read_q <= wb_dat_i[HC_READ_BIT];
            cnt_q     <= 8'(STROBE_CYC - 1);
            state_q   <= STROBE;
          end
        end
        STROBE: begin
          if (cnt_q == 8'h00) begin
            if (is_read_q) begin
              rdata_q <= d_s2_q;
            end
            cnt_q   <= 8'(RECOVER_CYC - 1);
            state_q <= RECOVER;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        RECOVER: begin
          if (cnt_q == 8'h00) begin
            state_q <= IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Command registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (wr_acc) begin
      if (idx == HOST_CTRL_IDX) begin
        drive_q <= wb_dat_i[HC_DRIVE_BIT];
      end
      if (idx == HOST_WDATA_IDX && state_q == IDLE) begin
        wdata_q <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (acc && !wb_we_i) begin
        case (idx)
          HOST_CTRL_IDX:   dat_q <= {29'h0, drive_q, 2'b00};
          HOST_WDATA_IDX:  dat_q <= {24'h00_0000, wdata_q};
          HOST_RDATA_IDX:  dat_q <= {24'h00_0000, rdata_q};
          HOST_STATUS_IDX: dat_q <= {31'h0, state_q != IDLE};
          default:         dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : upc_end

// ===== port_e_dev.sv
// Three-pin port with slave port control, register side on Wishbone
// Operation
// RULE1 - Each pin has its own direction bit
// RULE2 - Direction one releases driver, zero drives
// RULE3 - Mode bit four turns pins into controls
// RULE4 - Software sets direction bits before mode
// RULE5 - Software makes pins digital before mode
// RULE6 - Analog pins read back as zero
// RULE7 - Direction still drives pins when analog
// RULE8 - Pins start as analog inputs after reset
// RULE9 - Input full flag marks unread byte
// RULE10 - Register bit access and reset values
// RULE11 - Pin zero is low read strobe
// RULE12 - Pin one is low write strobe
// RULE13 - Pin two is low chip select
// RULE14 - Write happens when select, write first low
// RULE15 - Read happens when select, read first low
// RULE16 - Pin reads levels, writes load latch
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module port_e_dev
  import port_e_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_cyc_i,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  port_e_if.device              link
);
  logic [2:0]  pin_s1_q;
  logic [2:0]  pin_s2_q;
  logic [7:0]  d_s1_q;
  logic [7:0]  d_s2_q;
  logic [2:0]  dir_q;
  logic [2:0]  pin_latch_q;
  logic [2:0]  analog_cfg_q;
  logic        mode_q;
  logic        in_full_q;
  logic        out_full_q;
  logic        in_ovf_q;
  logic [7:0]  in_latch_q;
  logic [7:0]  out_latch_q;
  logic        wr_hit_q;
  logic        rd_hit_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  idx;
  logic [2:0]  analog_pins;
  logic [2:0]  pin_read;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_start;
  logic        rd_start;
  logic [7:0]  dir_ctrl_rd;

  // Bus decode
  assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_acc = acc & wb_we_i & wb_sel_i[0];
  assign rd_acc = acc & ~wb_we_i;
  assign idx    = wb_adr_i[9:2];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Pins and data bus pass two flops
  always_ff @(posedge clk_i) begin
    pin_s1_q <= link.pe;
    pin_s2_q <= pin_s1_q;
    d_s1_q   <= link.d;
    d_s2_q   <= d_s1_q;
  end

  // Pins are digital only with the all-digital settings
  assign analog_pins = (analog_cfg_q == ALL_DIGITAL ||
                        analog_cfg_q == MOST_DIGITAL) ? 3'h0 : 3'h7;
  assign pin_read = pin_s2_q & ~analog_pins;                  // [RULE6] [RULE16]

  // Drivers follow direction bits outside slave mode, even on analog pins
  assign link.pe_dev_oe = ~dir_q & {3{~mode_q}};              // [RULE1] [RULE2] [RULE3] [RULE7]
  assign link.pe_dev_o  = pin_latch_q;                        // [RULE16]

  // Strobe decode in slave mode
  assign wr_hit = mode_q & ~pin_s2_q[CS_PIN] & ~pin_s2_q[WR_PIN]; // [RULE12] [RULE13]
  assign rd_hit = mode_q & ~pin_s2_q[CS_PIN] & ~pin_s2_q[RD_PIN]; // [RULE11] [RULE13]
  assign wr_start = wr_hit & ~wr_hit_q;                       // [RULE14]
  assign rd_start = rd_hit & ~rd_hit_q;                       // [RULE15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_hit_q <= 1'b0;
      rd_hit_q <= 1'b0;
    end else begin
      wr_hit_q <= wr_hit;
      rd_hit_q <= rd_hit;
    end
  end

  // Data bus driven while the read strobe is seen
  assign link.d_dev_oe = rd_hit_q;                            // [RULE15]
  assign link.d_dev_o  = out_latch_q;

  // Direction, mode and analog configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q        <= DIR_RESET;                              // [RULE10]
      mode_q       <= 1'b0;                                   // [RULE10]
      analog_cfg_q <= ANALOG_RESET;                           // [RULE8]
    end else if (wr_acc) begin
      if (idx == DIR_CTRL_IDX) begin
        dir_q  <= wb_dat_i[2:0];
        mode_q <= wb_dat_i[SLV_MODE_BIT];                     // [RULE3]
      end
      if (idx == ANALOG_CFG_IDX) begin
        analog_cfg_q <= wb_dat_i[2:0];
      end
    end
  end

  // Output latch of the three pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_latch_q <= 3'h0;
    end else if (wr_acc && idx == PIN_VALUE_IDX) begin
      pin_latch_q <= wb_dat_i[2:0];                           // [RULE16]
    end
  end

  // Input byte from the external processor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_latch_q <= 8'h00;
    end else if (wr_start) begin
      in_latch_q <= d_s2_q;                                   // [RULE14]
    end
  end

  // Input full: set by an external write, cleared by a CPU read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_full_q <= 1'b0;
    end else if (wr_start) begin
      in_full_q <= 1'b1;                                      // [RULE9]
    end else if (rd_acc && idx == SLAVE_DATA_IDX) begin
      in_full_q <= 1'b0;                                      // [RULE9]
    end
  end

  // Overflow: write while full; software may write it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ovf_q <= 1'b0;
    end else if (wr_start && in_full_q) begin
      in_ovf_q <= 1'b1;
    end else if (wr_acc && idx == DIR_CTRL_IDX) begin
      in_ovf_q <= wb_dat_i[IN_OVF_BIT];                       // [RULE10]
    end
  end

  // Output byte and output full flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_latch_q <= 8'h00;
      out_full_q  <= 1'b0;
    end else if (wr_acc && idx == SLAVE_DATA_IDX) begin
      out_latch_q <= wb_dat_i[7:0];
      out_full_q  <= 1'b1;
    end else if (rd_start) begin
      out_full_q  <= 1'b0;                                    // [RULE15]
    end
  end

  // Interrupt status, cleared by a read, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == EV_IN_BIT && wr_start) ||
            (i == EV_OUT_BIT && rd_start) ||
            (i == EV_OVF_BIT && wr_start && in_full_q)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (rd_acc && idx == IRQ_STATUS_IDX) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= 3'h0;
    end else if (wr_acc && idx == IRQ_MASK_IDX) begin
      irq_mask_q <= wb_dat_i[2:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Read-only flags and a zero bit three
  assign dir_ctrl_rd = {in_full_q, out_full_q, in_ovf_q, mode_q,
                        1'b0, dir_q} & (DIR_CTRL_WMASK | 8'hc0); // [RULE10]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (rd_acc) begin
        case (idx)
          SLAVE_DATA_IDX: dat_q <= {24'h00_0000, in_latch_q};
          PIN_VALUE_IDX:  dat_q <= {29'h0, pin_read};         // [RULE6]
          DIR_CTRL_IDX:   dat_q <= {24'h00_0000, dir_ctrl_rd};
          ANALOG_CFG_IDX: dat_q <= {29'h0, analog_cfg_q};
          IRQ_STATUS_IDX: dat_q <= {29'h0, irq_stat_q};
          IRQ_MASK_IDX:   dat_q <= {29'h0, irq_mask_q};
          default:        dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : port_e_dev

// ===== port_e_link_monitor.sv
// Checker on the pin link between the two ends
`timescale 1ns/1ps
module port_e_link_monitor
  import port_e_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [2:0] pe_dev_oe,
  input wire logic [2:0] pe_ext_o,
  input wire logic [2:0] pe,
  input wire logic       d_dev_oe,
  input wire logic [7:0] d_ext_o,
  input wire logic       d_ext_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  host_data_strobe_a:
    assert property (d_ext_oe |-> !pe_ext_o[WR_PIN] && !pe_ext_o[CS_PIN])
    else $error("data driven outside write strobe");
  strobe_excl_a:
    assert property (pe_ext_o[RD_PIN] || pe_ext_o[WR_PIN])
    else $error("read and write strobes both low");
  data_excl_a:
    assert property (!(d_dev_oe && d_ext_oe))
    else $error("both ends drive data");
  read_start_a:
    assert property ($rose(d_dev_oe) |->
      $past(pe[RD_PIN], 2) == 1'b0 && $past(pe[CS_PIN], 2) == 1'b0)
    else $error("data driven without select and read");
  mode_pins_off_a:
    assert property (d_dev_oe |-> pe_dev_oe == 3'h0)
    else $error("pins driven in slave mode");
  write_len_a:
    assert property ($fell(pe_ext_o[WR_PIN]) |->
      (!pe_ext_o[WR_PIN] && !pe_ext_o[CS_PIN]) [*8])
    else $error("write strobe too short");
  read_len_a:
    assert property ($fell(pe_ext_o[RD_PIN]) |->
      (!pe_ext_o[RD_PIN] && !pe_ext_o[CS_PIN]) [*8])
    else $error("read strobe too short");
  recover_a:
    assert property ($rose(pe_ext_o[CS_PIN]) |-> pe_ext_o[CS_PIN] [*4])
    else $error("select recovery too short");
  wdata_stable_a:
    assert property (d_ext_oe && $past(d_ext_oe) |-> $stable(d_ext_o))
    else $error("write data changed in strobe");
endmodule : port_e_link_monitor

// ===== port_e_with_slave_port_control_tb_top.sv
// Testbench joining the port device and the microprocessor end
`timescale 1ns/1ps
module port_e_with_slave_port_control_tb_top;
  import port_e_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [9:0]  adr [2];
  logic [31:0] wd [2];
  logic [31:0] rdat [2];
  logic        we [2];
  logic        stb [2];
  logic        ack [2];
  logic        irq_o;
  int          num_errors;
  int          checks_done;
  int          k;
  logic [7:0]  b;
  logic [7:0]  e;
  logic [7:0]  q [$];

  port_e_if link ();
  port_e_dev i_port_e_dev (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr[0]),
    .wb_dat_i(wd[0]), .wb_dat_o(rdat[0]), .wb_we_i(we[0]), .wb_sel_i(4'hf),
    .wb_stb_i(stb[0]), .wb_cyc_i(stb[0]), .wb_ack_o(ack[0]),
    .irq_o(irq_o), .link(link.device));
  upc_end i_upc_end (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr[1]),
    .wb_dat_i(wd[1]), .wb_dat_o(rdat[1]), .wb_we_i(we[1]), .wb_sel_i(4'hf),
    .wb_stb_i(stb[1]), .wb_cyc_i(stb[1]), .wb_ack_o(ack[1]),
    .link(link.host));
  port_e_link_monitor i_port_e_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .pe_dev_oe(link.pe_dev_oe), .pe_ext_o(link.pe_ext_o), .pe(link.pe),
    .d_dev_oe(link.d_dev_oe), .d_ext_o(link.d_ext_o),
    .d_ext_oe(link.d_ext_oe));

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string nm, input logic [7:0] s,
                       input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  // One classic cycle, taken at the edge where ack is seen
  task automatic acc(input int m, input logic [7:0] ix, input logic w,
                     input logic [7:0] v, output logic [7:0] r);
    adr[m] <= {ix, 2'b00};
    wd[m] <= {24'h00_0000, v};
    we[m] <= w;
    stb[m] <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (ack[m] !== 1'b1);
    r = rdat[m][7:0];
    stb[m] <= 1'b0;
    @(posedge clk_i);
  endtask : acc

  task automatic wr(input int m, input logic [7:0] ix, input logic [7:0] v);
    logic [7:0] t;
    acc(m, ix, 1'b1, v, t);
  endtask : wr

  task automatic rc(input int m, input logic [7:0] ix, input logic [7:0] x,
                    input string nm);
    logic [7:0] t;
    acc(m, ix, 1'b0, 8'h00, t);
    check(nm, t, x);
  endtask : rc

  // Host cycle: write byte, start, wait for idle
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] v);
    logic [7:0] t;
    int n;
    wr(1, HOST_WDATA_IDX, v);
    wr(1, HOST_CTRL_IDX, ctl);
    t = 8'h01;
    for (n = 0; n < 40 && t[0] !== 1'b0; n++) begin
      acc(1, HOST_STATUS_IDX, 1'b0, 8'h00, t);
    end
    if (n >= 40) num_errors++;
  endtask : xfer

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_i = 1'b1;
    num_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 2; i++) begin
      adr[i] = 10'h000;
      wd[i] = 32'h0000_0000;
      we[i] = 1'b0;
      stb[i] = 1'b0;
    end
    k = $urandom(79);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(0, DIR_CTRL_IDX, 8'h07, "dir reset");
    rc(0, ANALOG_CFG_IDX, 8'h00, "cfg reset");
    rc(0, PIN_VALUE_IDX, 8'h00, "analog pins");
    rc(0, 8'h55, 8'h00, "unmapped");
    wr(0, DIR_CTRL_IDX, 8'hcf);
    rc(0, DIR_CTRL_IDX, 8'h07, "ro bits");
    wr(0, ANALOG_CFG_IDX, {5'h00, ALL_DIGITAL});
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom) & 8'h07;
      wr(0, PIN_VALUE_IDX, b);
      wr(0, DIR_CTRL_IDX, 8'(~i & 7));
      e = 8'((b & i) | (~i & 7));
      rc(0, PIN_VALUE_IDX, e, "pin level");
    end
    wr(0, ANALOG_CFG_IDX, {5'h00, MOST_DIGITAL});
    rc(0, PIN_VALUE_IDX, b, "cfg six");
    wr(0, ANALOG_CFG_IDX, 8'h00);
    rc(0, PIN_VALUE_IDX, 8'h00, "analog read");
    check("analog drive", {5'h00, link.pe}, b);
    wr(0, DIR_CTRL_IDX, 8'h07);
    wr(0, ANALOG_CFG_IDX, 8'h07);
    wr(0, IRQ_MASK_IDX, 8'h07);
    xfer(8'h05, 8'h3c);
    rc(0, IRQ_STATUS_IDX, 8'h00, "refused");
    wr(0, DIR_CTRL_IDX, 8'h17);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      xfer(8'h05, b);
      check("irq", {7'h00, irq_o}, 8'h01);
      rc(0, DIR_CTRL_IDX, 8'h97, "in full");
      rc(0, IRQ_STATUS_IDX, 8'h01, "rx event");
      rc(0, SLAVE_DATA_IDX, q.pop_front(), "rx byte");
      rc(0, DIR_CTRL_IDX, 8'h17, "in empty");
    end
    xfer(8'h05, 8'h11);
    xfer(8'h05, 8'h22);
    rc(0, DIR_CTRL_IDX, 8'hb7, "overflow");
    rc(0, IRQ_STATUS_IDX, 8'h05, "ovf event");
    acc(0, SLAVE_DATA_IDX, 1'b0, 8'h00, e);
    wr(0, DIR_CTRL_IDX, 8'h17);
    rc(0, DIR_CTRL_IDX, 8'h17, "ovf clear");
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      wr(0, SLAVE_DATA_IDX, b);
      rc(0, DIR_CTRL_IDX, 8'h57, "out full");
      xfer(8'h06, 8'h00);
      rc(1, HOST_RDATA_IDX, b, "ext read");
      rc(0, DIR_CTRL_IDX, 8'h17, "out taken");
      rc(0, IRQ_STATUS_IDX, 8'h02, "tx event");
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(0, DIR_CTRL_IDX, 8'h07, "second reset");
    end_of_test();
  end
endmodule : port_e_with_slave_port_control_tb_top
